// *** i2c_port_pkg.sv ***
// Constants, types and the slave-address table for the I2C register-access port.
// Assumes a single 40 MHz system clock; every other rate is derived from it.
package i2c_port_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned READY_TIME_NS = 200000;
  localparam int unsigned READY_CYCLES = (READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ***************************************************************
  // Fields, counts and reset values
  // ***************************************************************
  localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
  localparam logic [7:0] BURST_HOLD_REG = 8'h00;
  localparam logic [7:0] LAST_REG_DEFAULT = 8'h25;
  localparam logic [7:0] SECOND_CHAN_OFFSET = 8'h20;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int unsigned RW_BIT = 0;

  // Strap level codes: digital_ground, interface_supply_level, SCL, SDA.
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VL = 2'h1;
  localparam logic [1:0] STRAP_SCL = 2'h2;
  localparam logic [1:0] STRAP_SDA = 2'h3;

  // Write byte of the first_serial_channel, indexed by {addr_strap_high, addr_strap_low}.
  localparam logic [0:15][7:0] FIRST_CHAN_ADDR = {
    8'hD8, 8'hC2, 8'hC4, 8'hC6, 8'hC8, 8'hCA, 8'hCC, 8'hCE,
    8'hD0, 8'hD2, 8'hD4, 8'hD6, 8'hC0, 8'hDA, 8'hDC, 8'hDE};

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_REG = 3'h3,
    ST_WDATA = 3'h2,
    ST_RDATA = 3'h6
  } port_state_e;

  typedef struct packed {
    logic chan;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_s;

endpackage

// *** i2c_slave_port.sv ***
// I2C slave register-access port for a dual-channel serial bridge.
// Assumes SCL, SDA and the straps arrive synchronous to clk_in; the register file sits outside.
//
// How it works
// - Device answers a 7-bit address chosen so sixteen devices can share a bus.
// - Each strap decodes as ground, supply, SCL or SDA; sixteen address pairs result.
// - Direction bit high means read, low means write.
// - First byte after START or repeated START is the slave address.
// - Bits are sampled on SCL rise; SDA stays stable while SCL is high.
// - SDA change while SCL high is START or STOP, never data.
// - Idle bus: nobody pulls SCL or SDA low.
// - Acknowledge an address matching either channel; leave others unacknowledged.
// - Acknowledge the register address only when it names a valid register.
// - Each written data byte is stored and acknowledged.
// - Burst write advances the pointer, but holds it at register 0x00.
// - Single read returns one byte; master answers NACK then STOP.
// - Burst read continues while the master acknowledges each byte.
// - Acknowledge is SDA low across the whole ninth clock.
// - Not-acknowledge is SDA released across the whole ninth clock.
// - The port answers accesses only about 200 us after reset.
// - Interrupt request is an open-drain active-low output.
// - The port works as I2C only when the host port select says so.
// - Logic handles SCL rates up to 1 MHz.
`timescale 1ns/1ps
module i2c_slave_port
  import i2c_port_pkg::*;
#(
  parameter int unsigned READY_WAIT = READY_CYCLES,
  parameter logic [7:0] LAST_REG = LAST_REG_DEFAULT
)(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic host_port_spi_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  input wire logic addr_strap_high_in,
  input wire logic addr_strap_low_in,
  output reg_req_s reg_req_out,
  output logic wr_stb_out,
  output logic rd_req_out,
  input wire logic [7:0] rd_data_in,
  input wire logic irq_req_in,
  output logic irq_out,
  output logic irq_oe_b_out,
  output logic ready_out
);

  // ***************************************************************
  // Bus edges and conditions
  // ***************************************************************
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_w;
  logic stop_w;
  logic active;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_w = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_w = scl_in & scl_q & ~sda_q & sda_in;

  // ***************************************************************
  // Readiness after reset
  // ***************************************************************
  logic [$clog2(READY_WAIT + 1)-1:0] ready_cnt_q;
  logic ready_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ready_cnt_q <= '0;
      ready_q <= 1'b0;
    end
    else if (!ready_q)
    begin
      ready_cnt_q <= ready_cnt_q + 1'b1;
      ready_q <= (ready_cnt_q == ($clog2(READY_WAIT + 1))'(READY_WAIT - 1));
    end
  end

  assign active = ready_q & ~host_port_spi_in;

  // ***************************************************************
  // Strap decode
  // ***************************************************************
  // A strap is seen once with SCL high and SDA low and once the other way round.
  logic [1:0] strap_a_q;
  logic [1:0] strap_b_q;
  logic [1:0] code_hi;
  logic [1:0] code_lo;
  logic [7:0] chan0_byte;
  logic [7:0] chan1_byte;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      strap_a_q <= 2'h0;
      strap_b_q <= 2'h0;
    end
    else
    begin
      if (scl_in && !sda_in)
        strap_a_q <= {addr_strap_high_in, addr_strap_low_in};
      if (!scl_in && sda_in)
        strap_b_q <= {addr_strap_high_in, addr_strap_low_in};
    end
  end

  function automatic logic [1:0] strap_code(input logic a, input logic b);
    case ({a, b})
      2'b00: strap_code = STRAP_GND;
      2'b11: strap_code = STRAP_VL;
      2'b10: strap_code = STRAP_SCL;
      default: strap_code = STRAP_SDA;
    endcase
  endfunction

  assign code_hi = strap_code(strap_a_q[1], strap_b_q[1]);
  assign code_lo = strap_code(strap_a_q[0], strap_b_q[0]);
  assign chan0_byte = FIRST_CHAN_ADDR[{code_hi, code_lo}];
  assign chan1_byte = chan0_byte - SECOND_CHAN_OFFSET;

  // ***************************************************************
  // Byte engine
  // ***************************************************************
  port_state_e state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic ack_q;
  logic match0;
  logic match1;
  logic [7:0] ptr_next;

  assign match0 = shift_q[7:1] == chan0_byte[7:1];
  assign match1 = shift_q[7:1] == chan1_byte[7:1];
  assign ptr_next = (ptr_q == BURST_HOLD_REG) ? ptr_q : ptr_q + 8'h01;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= BYTE_RESET;
      ptr_q <= BYTE_RESET;
      reg_req_out <= '0;
    end
    else
    begin
      reg_req_out.addr <= ptr_q;
      if (!active || stop_w)
      begin
        state_q <= ST_IDLE;
        cnt_q <= 4'h0;
      end
      else if (start_w)
      begin
        state_q <= ST_DEV;
        cnt_q <= 4'h0;
      end
      else if (scl_rise && state_q != ST_IDLE)
      begin
        if (cnt_q != BIT_ACK_SLOT)
        begin
          shift_q <= {shift_q[6:0], sda_in};
          cnt_q <= cnt_q + 4'h1;
        end
        else
        begin
          cnt_q <= 4'h0;
          case (state_q)
            ST_DEV:
            begin
              reg_req_out.chan <= match1 & ~match0;
              if (!ack_q)
                state_q <= ST_IDLE;
              else if (shift_q[RW_BIT])
                state_q <= ST_RDATA;
              else
                state_q <= ST_REG;
            end
            ST_REG:
            begin
              ptr_q <= shift_q;
              state_q <= ack_q ? ST_WDATA : ST_IDLE;
            end
            ST_WDATA:
              ptr_q <= ptr_next;
            ST_RDATA:
            begin
              // The read request leaves in this cycle, so it must already carry the advanced pointer.
              ptr_q <= ptr_next;
              reg_req_out.addr <= ptr_next;
              if (sda_in)
                state_q <= ST_IDLE;
            end
            default:
              state_q <= ST_IDLE;
          endcase
        end
      end
      else if (scl_fall && state_q == ST_WDATA && cnt_q == BIT_ACK_SLOT)
        reg_req_out.data <= shift_q;
    end
  end

  // ***************************************************************
  // Register strobes and read data
  // ***************************************************************
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_stb_out <= 1'b0;
      rd_req_out <= 1'b0;
      tx_q <= BYTE_RESET;
    end
    else
    begin
      wr_stb_out <= active && !start_w && !stop_w && scl_fall && state_q == ST_WDATA
                    && cnt_q == BIT_ACK_SLOT;
      rd_req_out <= active && !start_w && !stop_w && scl_rise && cnt_q == BIT_ACK_SLOT
                    && ((state_q == ST_DEV && ack_q && shift_q[RW_BIT])
                    || (state_q == ST_RDATA && !sda_in));
      if (scl_fall && state_q == ST_RDATA && cnt_q == 4'h0)
        tx_q <= rd_data_in;
    end
  end

  // ***************************************************************
  // SDA driver
  // ***************************************************************
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sda_oe_b_out <= 1'b1;
      sda_out <= 1'b0;
      ack_q <= 1'b0;
    end
    else if (!active || start_w || stop_w || state_q == ST_IDLE)
      sda_oe_b_out <= 1'b1;
    else if (scl_fall)
    begin
      if (cnt_q == BIT_ACK_SLOT)
      begin
        case (state_q)
          ST_DEV:
          begin
            ack_q <= match0 | match1;
            sda_oe_b_out <= ~(match0 | match1);
          end
          ST_REG:
          begin
            ack_q <= shift_q <= LAST_REG;
            sda_oe_b_out <= ~(shift_q <= LAST_REG);
          end
          ST_WDATA:
            sda_oe_b_out <= 1'b0;
          default:
            sda_oe_b_out <= 1'b1;
        endcase
      end
      else if (state_q == ST_RDATA)
        sda_oe_b_out <= (cnt_q == 4'h0) ? rd_data_in[7] : tx_q[3'(4'h7 - cnt_q)];
      else
        sda_oe_b_out <= 1'b1;
    end
  end

  // ***************************************************************
  // Interrupt and ready outputs
  // ***************************************************************
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      irq_out <= 1'b0;
      irq_oe_b_out <= 1'b1;
      ready_out <= 1'b0;
    end
    else
    begin
      irq_oe_b_out <= ~irq_req_in;
      ready_out <= ready_q;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  logic slot_fall;
  logic slot_rise;

  assign slot_fall = active && !stop_w && !start_w && scl_fall && cnt_q == BIT_ACK_SLOT;
  assign slot_rise = active && !stop_w && !start_w && scl_rise && cnt_q == BIT_ACK_SLOT;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  idle_release_a: assert property (state_q == ST_IDLE |=> sda_oe_b_out) else $error("SDA held while idle.");
  start_addr_a: assert property (active && start_w |=> state_q == ST_DEV && cnt_q == 4'h0)
    else $error("START did not begin address phase.");
  addr_ack_a: assert property (slot_fall && state_q == ST_DEV |=> sda_oe_b_out == !$past(match0 || match1))
    else $error("Address acknowledge wrong.");
  reg_nack_a: assert property (slot_fall && state_q == ST_REG && shift_q > LAST_REG |=> sda_oe_b_out)
    else $error("Invalid register acknowledged.");
  write_store_a: assert property (slot_fall && state_q == ST_WDATA |=> wr_stb_out && !sda_oe_b_out
    && reg_req_out.data == $past(shift_q)) else $error("Write byte not stored.");
  ptr_step_a: assert property (slot_rise && state_q == ST_WDATA
    |=> ptr_q == (($past(ptr_q) == 8'h00) ? 8'h00 : $past(ptr_q) + 8'h01))
    else $error("Burst pointer step wrong.");
  read_dir_a: assert property (slot_rise && state_q == ST_DEV && ack_q && shift_q[0]
    |=> state_q == ST_RDATA && rd_req_out ##1 !rd_req_out) else $error("Read not entered.");
  read_addr_a: assert property (slot_rise && state_q == ST_RDATA && !sda_in
    |=> rd_req_out && reg_req_out.addr == ptr_q) else $error("Read address not advanced.");
  read_end_a: assert property (slot_rise && state_q == ST_RDATA && sda_in
    |=> state_q == ST_IDLE && !rd_req_out) else $error("Read kept after NACK.");
  high_stable_a: assert property (scl_in && scl_q && !start_w && !stop_w |-> $stable(sda_oe_b_out))
    else $error("SDA moved while SCL high.");
  wait_ready_a: assert property (!ready_q || host_port_spi_in |=> state_q == ST_IDLE)
    else $error("Port active before ready.");
  irq_drive_a: assert property (irq_req_in |=> !irq_oe_b_out && !irq_out) else $error("IRQ not pulled low.");

  write_seen_c: cover property (wr_stb_out ##[1:1000] wr_stb_out);
  read_seen_c: cover property (rd_req_out ##[1:1000] rd_req_out);
  reg_nack_c: cover property (state_q == ST_REG ##1 state_q == ST_IDLE);

endmodule

// *** i2c_host_model.sv ***
// Behavioural I2C bus master standing in for the host microcontroller.
// Assumes a pull-up on SDA: the bench ANDs sda_out with the device's drive.
`timescale 1ns/1ps
module i2c_host_model
#(
  // Forty clocks per bit keep SCL at the 1 MHz ceiling.
  parameter int unsigned HALF = 19
)(
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // ***************************************************************
  // Bus conditions
  // ***************************************************************
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Works from idle as a START and after a byte as a repeated START.
  task automatic start_cond();
    hold(2);
    sda_out <= 1'b1;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    sda_out <= 1'b0;
    hold(HALF);
    scl_out <= 1'b0;
  endtask

  task automatic stop_cond();
    hold(2);
    sda_out <= 1'b0;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    sda_out <= 1'b1;
    hold(HALF);
  endtask

  // ***************************************************************
  // Bits and bytes
  // ***************************************************************
  task automatic xfer_bit(input logic b, output logic r);
    hold(2);
    sda_out <= b;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    r = sda_in;
    scl_out <= 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(v[i], r);
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(1'b1, v[i]);
    xfer_bit(~ack, r);
  endtask
endmodule

// *** test_i2c_slave_port.sv ***
// Self-checking bench for the I2C slave port, with a host model as bus master.
// Assumes straps grounded, so the two channel write bytes are fixed.
`timescale 1ns/1ps
module test_i2c_slave_port
  import i2c_port_pkg::*;
;
  localparam int unsigned WAIT = 1000;
  localparam logic [7:0] DEV0 = 8'hD8;
  localparam logic [7:0] DEV1 = 8'hB8;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic spi_sel = 1'b0;
  logic scl, m_sda, sda_wire, sda_o, sda_oe_b, wr_stb, rd_req, irq_o, irq_oe_b, ready, a;
  logic irq_req = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] v;
  reg_req_s reg_req;
  reg_req_s wq[$];
  int rd_cnt = 0;
  int mismatches = 0;
  int check_count = 0;

  assign sda_wire = m_sda & (sda_oe_b ? 1'b1 : sda_o);

  i2c_host_model u_i2c_host_model (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_out(m_sda));

  i2c_slave_port #(.READY_WAIT(WAIT)) u_i2c_slave_port (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .host_port_spi_in(spi_sel), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_o), .sda_oe_b_out(sda_oe_b),
    .addr_strap_high_in(1'b0), .addr_strap_low_in(1'b0), .reg_req_out(reg_req), .wr_stb_out(wr_stb),
    .rd_req_out(rd_req), .rd_data_in(rd_data), .irq_req_in(irq_req), .irq_out(irq_o),
    .irq_oe_b_out(irq_oe_b), .ready_out(ready));

  // ***************************************************************
  // Register file stand-in: reads return the address XOR 0x5A
  // ***************************************************************
  always @(posedge clk_in)
  begin
    if (wr_stb === 1'b1) wq.push_back(reg_req);
    if (rd_req === 1'b1)
    begin
      rd_data <= reg_req.addr ^ 8'h5A;
      rd_cnt++;
    end
  end

  // ***************************************************************
  // Compare and closing
  // ***************************************************************
  task automatic check_bit(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic check_word(input logic [16:0] got, input logic [16:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic wr_burst(input logic [7:0] dev, input logic [7:0] rg, input int n, input logic [7:0] d0);
    u_i2c_host_model.start_cond();
    u_i2c_host_model.send_byte(dev, a);
    check_bit(a, 1'b1, "dev ack");
    u_i2c_host_model.send_byte(rg, a);
    check_bit(a, 1'b1, "reg ack");
    for (int i = 0; i < n; i++)
    begin
      u_i2c_host_model.send_byte(d0 + 8'(i), a);
      check_bit(a, 1'b1, "data ack");
    end
    u_i2c_host_model.stop_cond();
  endtask

  task automatic t_ready();
    u_i2c_host_model.start_cond();
    u_i2c_host_model.send_byte(DEV0, a);
    check_bit(a, 1'b0, "early ack");
    check_bit(ready, 1'b0, "early ready");
    u_i2c_host_model.stop_cond();
    repeat (WAIT) @(posedge clk_in);
    check_bit(ready, 1'b1, "ready");
    $display("test ready done");
  endtask

  task automatic t_writes();
    wr_burst(DEV0, 8'h24, 2, 8'h11);
    wr_burst(DEV1, 8'h00, 3, 8'h30);
    check_word(17'(wq.size()), 17'h5, "write count");
    check_word(wq[0], {1'b0, 8'h24, 8'h11}, "write 0");
    check_word(wq[1], {1'b0, 8'h25, 8'h12}, "write 1");
    for (int i = 2; i < 5; i++) check_word(wq[i], {1'b1, 8'h00, 8'h2E + 8'(i)}, "hold 0");
    wq.delete();
    $display("test writes done");
  endtask

  task automatic t_refuse();
    u_i2c_host_model.start_cond();
    u_i2c_host_model.send_byte(8'h50, a);
    check_bit(a, 1'b0, "foreign ack");
    u_i2c_host_model.stop_cond();
    u_i2c_host_model.start_cond();
    u_i2c_host_model.send_byte(DEV0, a);
    u_i2c_host_model.send_byte(8'h26, a);
    check_bit(a, 1'b0, "bad reg ack");
    u_i2c_host_model.send_byte(8'h77, a);
    check_bit(a, 1'b0, "after nack");
    u_i2c_host_model.stop_cond();
    spi_sel <= 1'b1;
    u_i2c_host_model.start_cond();
    u_i2c_host_model.send_byte(DEV0, a);
    check_bit(a, 1'b0, "spi mode ack");
    u_i2c_host_model.stop_cond();
    spi_sel <= 1'b0;
    check_word(17'(wq.size()), 17'h0, "no write");
    $display("test refuse done");
  endtask

  task automatic t_reads();
    logic [7:0] rg[2] = '{8'h03, 8'h00};
    logic [7:0] nx[2] = '{8'h04, 8'h00};
    for (int k = 0; k < 2; k++)
    begin
      rd_cnt = 0;
      u_i2c_host_model.start_cond();
      u_i2c_host_model.send_byte(DEV0, a);
      u_i2c_host_model.send_byte(rg[k], a);
      u_i2c_host_model.start_cond();
      u_i2c_host_model.send_byte(DEV0 | 8'h01, a);
      check_bit(a, 1'b1, "read ack");
      u_i2c_host_model.recv_byte(1'b1, v);
      check_word(17'(v), 17'(rg[k] ^ 8'h5A), "read 0");
      u_i2c_host_model.recv_byte(1'b0, v);
      check_word(17'(v), 17'(nx[k] ^ 8'h5A), "read 1");
      u_i2c_host_model.stop_cond();
      check_word(17'(rd_cnt), 17'h2, "read count");
      check_bit(sda_wire, 1'b1, "idle sda");
    end
    $display("test reads done");
  endtask

  task automatic t_irq();
    irq_req <= 1'b1;
    repeat (3) @(posedge clk_in);
    check_bit(irq_oe_b, 1'b0, "irq pull");
    check_bit(irq_o, 1'b0, "irq level");
    irq_req <= 1'b0;
    repeat (3) @(posedge clk_in);
    check_bit(irq_oe_b, 1'b1, "irq release");
    $display("test irq done");
  endtask

  // ***************************************************************
  // Clock, reset, sequence and watchdog
  // ***************************************************************
  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end

  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_ready();
    t_writes();
    t_refuse();
    t_reads();
    t_irq();
    end_of_test();
  end

  initial
  begin
    repeat (60000) @(posedge clk_in);
    mismatches++;
    end_of_test();
  end
endmodule
